// ### src/smrc_defines.svh
// Purpose: shared constants of the serial register client
// Assumes: 25 MHz reference clock
// Notes: timing counts are derived from the printed times
`ifndef SMRC_DEFINES_SVH
`define SMRC_DEFINES_SVH

// ----------------------------------------
// bus identity and widths
// ----------------------------------------
`define SMRC_CLIENT_ADDR 7'h28
`define SMRC_BYTE_W 8
`define SMRC_CH_N 3
`define SMRC_PTR_RST 8'h00
`define SMRC_CNT_W 20

// ----------------------------------------
// timing
// ----------------------------------------
`define SMRC_CLK_HZ 25000000
`define SMRC_SCL_MIN_KHZ 10
`define SMRC_SCL_MAX_KHZ 400
`define SMRC_TIMEOUT_MS 30
`define SMRC_IDLE_US 200
`define SMRC_TIMEOUT_CYC (`SMRC_TIMEOUT_MS * (`SMRC_CLK_HZ / 1000))
`define SMRC_IDLE_CYC (`SMRC_IDLE_US * (`SMRC_CLK_HZ / 1000000))

`endif

// ### src/smrc_pkg.sv
// Purpose: types of the serial register client
// Assumes: nothing
// Notes: state codes follow declaration order, counting from 0
package smrc_pkg;
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DEVADDR,
    PH_REGADDR,
    PH_WRITE,
    PH_READ,
    PH_IGNORE
  } smrc_phase_t;

  typedef enum logic [1:0] {
    PS_ACTIVE,
    PS_STANDBY,
    PS_DEEP
  } smrc_pstate_t;
endpackage

// ### src/smrc_pwr_if.sv
// Purpose: link between protocol engine and power-state keeper
// Assumes: single clock
// Notes: power side owns every flop here
`timescale 1ns/10ps
interface smrc_pwr_if;
  logic busBusy;
  smrc_pkg::smrc_pstate_t pState;
  logic awake;
  logic [2:0] touchStatus;
  logic touchAlert;

  modport client (
    output busBusy,
    input pState,
    input awake,
    input touchStatus,
    input touchAlert
  );

  modport power (
    input busBusy,
    output pState,
    output awake,
    output touchStatus,
    output touchAlert
  );
endinterface

// ### src/smrc_power.sv
// Purpose: power state and touch status keeper
// Assumes: control bits and touch events on ref_clk
// Notes: bus traffic wakes without touching the sleep bit
`timescale 1ns/10ps
`include "smrc_defines.svh"
module smrc_power (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // link to protocol engine
  smrc_pwr_if.power pw,
  // control bits
  input wire logic standbyReqBit,
  input wire logic deepSleepBit,
  input wire logic [`SMRC_CH_N-1:0] activeEnMask,
  input wire logic [`SMRC_CH_N-1:0] standbyEnMask,
  input wire logic alertEn,
  // touch events
  input wire logic [`SMRC_CH_N-1:0] touchDetect,
  input wire logic touchClr
);
  smrc_pkg::smrc_pstate_t pNext;
  logic [`SMRC_CH_N-1:0] monMask;
  logic [`SMRC_CH_N-1:0] status_d;

  // ----------------------------------------
  // state selection
  // ----------------------------------------
  always_comb
  begin
    if (deepSleepBit)
      pNext = smrc_pkg::PS_DEEP;
    else if (standbyReqBit)
      pNext = smrc_pkg::PS_STANDBY;
    else
      pNext = smrc_pkg::PS_ACTIVE;
  end

  always_comb
  begin
    unique case (pw.pState)
      smrc_pkg::PS_ACTIVE: monMask = activeEnMask;
      smrc_pkg::PS_STANDBY: monMask = standbyEnMask;
      default: monMask = '0;
    endcase
  end

  // set wins over a host clear; a state change wipes everything
  always_comb
  begin
    if (pNext != pw.pState)
      status_d = '0;
    else
      status_d = (pw.touchStatus & ~{`SMRC_CH_N{touchClr}}) | (touchDetect & monMask);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pw.pState <= smrc_pkg::PS_ACTIVE;
    else
      pw.pState <= pNext;
  end

  // sleep bit stays set; awake only while traffic lasts
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pw.awake <= 1'b1;
    else
      pw.awake <= (pNext != smrc_pkg::PS_DEEP) || pw.busBusy;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pw.touchStatus <= '0;
      pw.touchAlert <= 1'b0;
    end
    else
    begin
      pw.touchStatus <= status_d;
      pw.touchAlert <= alertEn && (status_d != '0);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  state_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (pNext != pw.pState) |=> (pw.touchStatus == '0)) else $error("status kept");
  deep_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    deepSleepBit [*3] |-> (pw.touchStatus == '0)) else $error("deep sleep set status");
  sleep_back_a: assert property (@(posedge ref_clk) disable iff (rst)
    (deepSleepBit && !pw.busBusy) [*2] |-> !pw.awake) else $error("no return to sleep");
  traffic_wake_a: assert property (@(posedge ref_clk) disable iff (rst)
    pw.busBusy |=> pw.awake) else $error("traffic did not wake");
  standby_state_a: assert property (@(posedge ref_clk) disable iff (rst)
    (standbyReqBit && !deepSleepBit) |=> (pw.pState == smrc_pkg::PS_STANDBY))
    else $error("standby not entered");
endmodule

// ### src/smrc_client.sv
// Purpose: two-wire client reaching a byte-wide register space
// Assumes: pins asynchronous to ref_clk, 25 MHz clock
// Notes: never stretches the clock; sda is open drain
`timescale 1ns/10ps
`include "smrc_defines.svh"
module smrc_client #(
  parameter int unsigned TIMEOUT_CYC = `SMRC_TIMEOUT_CYC,
  parameter int unsigned IDLE_CYC = `SMRC_IDLE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // register space
  output logic regWrEn,
  output logic [`SMRC_BYTE_W-1:0] regWrAddr,
  output logic [`SMRC_BYTE_W-1:0] regWrData,
  output logic [`SMRC_BYTE_W-1:0] regRdAddr,
  input wire logic [`SMRC_BYTE_W-1:0] regRdData,
  // control bits
  input wire logic timeoutEn,
  input wire logic standbyReqBit,
  input wire logic deepSleepBit,
  input wire logic [`SMRC_CH_N-1:0] activeEnMask,
  input wire logic [`SMRC_CH_N-1:0] standbyEnMask,
  input wire logic alertEn,
  // touch status and power state
  input wire logic [`SMRC_CH_N-1:0] touchDetect,
  input wire logic touchClr,
  output logic [`SMRC_CH_N-1:0] touchStatus,
  output logic touchAlert,
  output smrc_pkg::smrc_pstate_t powerState,
  output logic deviceAwake
);
  localparam logic [`SMRC_CNT_W-1:0] LOW_LIM = `SMRC_CNT_W'(TIMEOUT_CYC);
  localparam logic [`SMRC_CNT_W-1:0] IDLE_LIM = `SMRC_CNT_W'(IDLE_CYC);

  smrc_pwr_if pw ();

  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  logic sclS;
  logic sdaS;
  logic [`SMRC_CNT_W-1:0] lowCnt_q;
  logic [`SMRC_CNT_W-1:0] idleCnt_q;
  logic tmoEn_q;
  logic tmoFire;
  smrc_pkg::smrc_phase_t phase_q;
  logic [3:0] bitCnt_q;
  logic ackPh_q;
  logic [`SMRC_BYTE_W-1:0] rxSr_q;
  logic [`SMRC_BYTE_W-1:0] txByte_q;
  logic txValid_q;
  logic mNack_q;
  logic [`SMRC_BYTE_W-1:0] ptr_q;
  logic sdaOe_q;
  logic sdaOut_q;
  logic regWrEn_q;
  logic [`SMRC_BYTE_W-1:0] regWrAddr_q;
  logic [`SMRC_BYTE_W-1:0] regWrData_q;
  logic startDet;
  logic stopDet;
  logic live;
  logic bitRise;
  logic ackRise;
  logic byteDone;
  logic ackEnd;
  logic addrHit;

  // decides whether a finished byte earns our ack
  function automatic logic ackByte(smrc_pkg::smrc_phase_t ph, logic hit);
    logic r;
    r = 1'b0;
    unique case (ph)
      smrc_pkg::PH_DEVADDR: r = hit;
      smrc_pkg::PH_REGADDR: r = 1'b1;
      smrc_pkg::PH_WRITE: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------
  // 62.5 clocks per bit at 400 kHz maximum, so edges are never missed
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end
    else
    begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
    end
  end

  assign sclS = sclSync_q[1];
  assign sdaS = sdaSync_q[1];
  assign startDet = sclS && sclPrev_q && sdaPrev_q && !sdaS;
  assign stopDet = sclS && sclPrev_q && !sdaPrev_q && sdaS;
  assign live = !tmoFire && !stopDet && !startDet;
  assign bitRise = live && sclS && !sclPrev_q && !ackPh_q && (bitCnt_q < 4'h8);
  assign ackRise = live && sclS && !sclPrev_q && ackPh_q;
  assign byteDone = live && !sclS && sclPrev_q && !ackPh_q && (bitCnt_q == 4'h8);
  assign ackEnd = live && !sclS && sclPrev_q && ackPh_q;
  assign addrHit = (rxSr_q[7:1] == `SMRC_CLIENT_ADDR);

  // ----------------------------------------
  // timeout and idle watch
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      tmoEn_q <= 1'b0;
    else
      tmoEn_q <= timeoutEn;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || !tmoEn_q || sclS)
      lowCnt_q <= '0;
    else if (lowCnt_q != LOW_LIM)
      lowCnt_q <= lowCnt_q + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || !tmoEn_q || !(sclS && sdaS))
      idleCnt_q <= '0;
    else if (idleCnt_q != IDLE_LIM)
      idleCnt_q <= idleCnt_q + 1'b1;
  end

  assign tmoFire = tmoEn_q && ((lowCnt_q == LOW_LIM) || (idleCnt_q == IDLE_LIM));

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    regWrEn_q <= 1'b0;
    sdaOut_q <= 1'b0;
    if (rst || tmoFire || stopDet)
    begin
      phase_q <= smrc_pkg::PH_IDLE;
      bitCnt_q <= '0;
      ackPh_q <= 1'b0;
      sdaOe_q <= 1'b0;
      txValid_q <= 1'b0;
      mNack_q <= 1'b0;
      if (rst)
      begin
        rxSr_q <= '0;
        txByte_q <= '0;
        regWrAddr_q <= '0;
        regWrData_q <= '0;
      end
    end
    else if (startDet)
    begin
      phase_q <= smrc_pkg::PH_DEVADDR;
      bitCnt_q <= '0;
      ackPh_q <= 1'b0;
      sdaOe_q <= 1'b0;
      txValid_q <= 1'b0;
    end
    else if (bitRise)
    begin
      rxSr_q <= {rxSr_q[6:0], sdaS};
      bitCnt_q <= bitCnt_q + 4'h1;
    end
    else if (ackRise)
      mNack_q <= sdaS;
    else if (byteDone)
    begin
      ackPh_q <= 1'b1;
      sdaOe_q <= ackByte(phase_q, addrHit);
      unique case (phase_q)
        smrc_pkg::PH_DEVADDR:
        begin
          mNack_q <= 1'b0;
          if (!addrHit)
            phase_q <= smrc_pkg::PH_IGNORE;
          else if (rxSr_q[0])
            phase_q <= smrc_pkg::PH_READ;
          else
            phase_q <= smrc_pkg::PH_REGADDR;
        end
        smrc_pkg::PH_REGADDR:
          phase_q <= smrc_pkg::PH_WRITE;
        smrc_pkg::PH_WRITE:
        begin
          regWrEn_q <= 1'b1;
          regWrAddr_q <= ptr_q;
          regWrData_q <= rxSr_q;
        end
        default:
          phase_q <= phase_q;
      endcase
    end
    else if (ackEnd)
    begin
      ackPh_q <= 1'b0;
      bitCnt_q <= '0;
      if (phase_q == smrc_pkg::PH_READ && !mNack_q)
      begin
        txByte_q <= regRdData;
        txValid_q <= 1'b1;
        sdaOe_q <= !regRdData[7];
      end
      else
      begin
        sdaOe_q <= 1'b0;
        if (phase_q == smrc_pkg::PH_READ)
          phase_q <= smrc_pkg::PH_IGNORE;
      end
    end
    else if (live && !sclS && sclPrev_q && phase_q == smrc_pkg::PH_READ && bitCnt_q != 4'h0)
      sdaOe_q <= !txByte_q[3'h7 - bitCnt_q[2:0]];
  end

  // ----------------------------------------
  // register pointer
  // ----------------------------------------
  // a nacked byte leaves the pointer, so repeated pointer reads agree
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ptr_q <= `SMRC_PTR_RST;
    else if (byteDone && phase_q == smrc_pkg::PH_REGADDR)
      ptr_q <= rxSr_q;
    else if (byteDone && phase_q == smrc_pkg::PH_WRITE)
      ptr_q <= ptr_q + 8'h01;
    else if (ackRise && phase_q == smrc_pkg::PH_READ && txValid_q && !sdaS)
      ptr_q <= ptr_q + 8'h01;
  end

  // ----------------------------------------
  // power keeper and outputs
  // ----------------------------------------
  assign pw.busBusy = (phase_q != smrc_pkg::PH_IDLE) && (phase_q != smrc_pkg::PH_IGNORE);

  smrc_power u_power (
    .ref_clk(ref_clk),
    .rst(rst),
    .pw(pw.power),
    .standbyReqBit(standbyReqBit),
    .deepSleepBit(deepSleepBit),
    .activeEnMask(activeEnMask),
    .standbyEnMask(standbyEnMask),
    .alertEn(alertEn),
    .touchDetect(touchDetect),
    .touchClr(touchClr)
  );

  assign sdaOut = sdaOut_q;
  assign sdaOe = sdaOe_q;
  assign regWrEn = regWrEn_q;
  assign regWrAddr = regWrAddr_q;
  assign regWrData = regWrData_q;
  assign regRdAddr = ptr_q;
  assign touchStatus = pw.touchStatus;
  assign touchAlert = pw.touchAlert;
  assign powerState = pw.pState;
  assign deviceAwake = pw.awake;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  stop_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    stopDet |=> (phase_q == smrc_pkg::PH_IDLE) && !sdaOe_q) else $error("stop ignored");
  ack_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    (byteDone && ackByte(phase_q, addrHit)) |=> sdaOe_q && !sdaOut_q)
    else $error("byte not acked");
  ptr_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    (byteDone && phase_q == smrc_pkg::PH_REGADDR) |=> !regWrEn_q && (ptr_q == $past(rxSr_q)))
    else $error("pointer set wrong");
  wr_inc_a: assert property (@(posedge ref_clk) disable iff (rst)
    regWrEn_q |-> (ptr_q == regWrAddr_q + 8'h01)) else $error("write pointer stuck");
  rd_inc_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ackRise && phase_q == smrc_pkg::PH_READ && txValid_q && !sdaS)
    |=> (ptr_q == $past(ptr_q) + 8'h01)) else $error("read pointer stuck");
  rd_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ackRise && phase_q == smrc_pkg::PH_READ && sdaS) |=> $stable(ptr_q))
    else $error("nack moved pointer");
  tmo_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !timeoutEn [*2] |-> !tmoFire) else $error("timeout while disabled");
  tmo_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    tmoFire |=> (phase_q == smrc_pkg::PH_IDLE) && !sdaOe_q) else $error("timeout ignored");
  rd_first_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ackEnd && phase_q == smrc_pkg::PH_READ && !mNack_q) |=> (sdaOe_q == !txByte_q[7]))
    else $error("msb not first");
endmodule

// ### tb/smrc_host.sv
// Purpose: host model that masters the two-wire bus
// Assumes: pull-up on the data line, bus clock period 320 ns
// Notes: clock stands high between frames; hiX stretches one high phase
`timescale 1ns/10ps
module smrc_host (
  // bus lines
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaBus
);
  localparam int Q = 80;
  int hiX = 0;

  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // data changes only while the clock is low
  task automatic slot(input logic b, output logic s);
    #Q sdaDrv = b;
    #Q scl = 1'b1;
    #(Q + hiX) s = sdaBus;
    hiX = 0;
    #Q scl = 1'b0;
  endtask

  // extra quarter lets a client release its ack before the clock rises
  task automatic start();
    #(2 * Q) sdaDrv = 1'b1;
    #Q scl = 1'b1;
    #Q sdaDrv = 1'b0;
    #Q scl = 1'b0;
  endtask

  task automatic stop();
    #(2 * Q) sdaDrv = 1'b0;
    #Q scl = 1'b1;
    #Q sdaDrv = 1'b1;
    #Q;
  endtask

  // hAck is the host's ninth bit; 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic hAck, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      slot(d[i], q[i]);
    end
    slot(hAck, ack);
  endtask
endmodule

// ### tb/tb.sv
// Purpose: self-checking bench of the serial register client
// Assumes: register space modelled here as a 256-byte array
// Notes: timeout counts shortened through parameters
`timescale 1ns/10ps
`include "smrc_defines.svh"
module tb;
  localparam int unsigned TO_CYC = 200;
  localparam int unsigned IDLE_C = 60;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sclIn, sdaHost, sdaOe, regWrEn, touchAlert, deviceAwake;
  logic [7:0] regWrAddr, regWrData, regRdAddr, regRdData;
  logic timeoutEn = 1'b0;
  logic standbyReqBit = 1'b0;
  logic deepSleepBit = 1'b0;
  logic alertEn = 1'b1;
  logic touchClr = 1'b0;
  logic [2:0] activeEnMask = 3'h3;
  logic [2:0] standbyEnMask = 3'h4;
  logic [2:0] touchDetect = 3'h0;
  logic [2:0] touchStatus;
  smrc_pkg::smrc_pstate_t powerState;
  logic [7:0] mem [256];
  logic [7:0] none[$];
  logic sawAwake;
  int nWr = 0;
  int n_fail = 0;
  int comparisons = 0;
  // open drain: device can only pull low
  wire sdaBus = sdaHost & ~sdaOe;

  always #20 ref_clk = ~ref_clk;
  assign regRdData = mem[regRdAddr];
  always @(posedge ref_clk)
  begin
    if (regWrEn)
    begin
      mem[regWrAddr] <= regWrData;
      nWr++;
    end
    if (deviceAwake)
      sawAwake = 1'b1;
  end

  smrc_host host (.scl(sclIn), .sdaDrv(sdaHost), .sdaBus(sdaBus));

  smrc_client #(.TIMEOUT_CYC(TO_CYC), .IDLE_CYC(IDLE_C)) DUT (
    .ref_clk(ref_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaBus), .sdaOut(), .sdaOe(sdaOe),
    .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .timeoutEn(timeoutEn),
    .standbyReqBit(standbyReqBit), .deepSleepBit(deepSleepBit),
    .activeEnMask(activeEnMask), .standbyEnMask(standbyEnMask), .alertEn(alertEn),
    .touchDetect(touchDetect), .touchClr(touchClr), .touchStatus(touchStatus),
    .touchAlert(touchAlert), .powerState(powerState), .deviceAwake(deviceAwake));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic hdr(input logic [7:0] a);
    logic [7:0] d;
    logic k;
    host.start();
    host.xfer({`SMRC_CLIENT_ADDR, 1'b0}, 1'b1, d, k);
    chk({7'h00, k}, 8'h00, "addr ack");
    host.xfer(a, 1'b1, d, k);
    chk({7'h00, k}, 8'h00, "reg ack");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v[$]);
    logic [7:0] d;
    logic k;
    hdr(a);
    foreach (v[i])
    begin
      host.xfer(v[i], 1'b1, d, k);
      chk({7'h00, k}, 8'h00, "data ack");
    end
    host.stop();
  endtask

  task automatic rd(input logic setPtr, input logic [7:0] a, input int n,
                    output logic [7:0] q[$]);
    logic [7:0] d;
    logic k;
    q = {};
    if (setPtr)
      hdr(a);
    host.start();
    host.xfer({`SMRC_CLIENT_ADDR, 1'b1}, 1'b1, d, k);
    chk({7'h00, k}, 8'h00, "read addr ack");
    for (int i = 0; i < n; i++)
    begin
      host.xfer(8'hff, i == n - 1, d, k);
      q.push_back(d);
    end
    host.stop();
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #2000000;
    n_fail++;
    final_report();
  end

  initial
  begin
    logic [7:0] q[$];
    logic [7:0] d;
    logic k;
    int n;
    bit en;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(regRdAddr, 8'h00, "ptr at reset");
    wr(8'h10, '{8'hab});
    chk(mem[8'h10], 8'hab, "single write");
    chk(regRdAddr, 8'h11, "ptr after write");
    wr(8'hfe, '{8'h01, 8'h02, 8'h03});
    chk(mem[8'hfe], 8'h01, "block fe");
    chk(mem[8'hff], 8'h02, "block ff");
    chk(mem[8'h00], 8'h03, "block wrap");
    chk(regRdAddr, 8'h01, "ptr wrap");
    rd(1'b1, 8'hfe, 1, q);
    chk(q[0], 8'h01, "single read");
    rd(1'b1, 8'hff, 3, q);
    chk(q[0], 8'h02, "block read ff");
    chk(q[1], 8'h03, "block read wrap");
    chk(q[2], 8'h5b, "block read 01");
    n = nWr;
    wr(8'h40, none);
    chk(8'(nWr - n), 8'h00, "set ptr no write");
    chk(regRdAddr, 8'h40, "set ptr");
    repeat (2)
    begin
      rd(1'b0, 8'h00, 1, q);
      chk(q[0], 8'h1a, "ptr read");
    end
    chk(regRdAddr, 8'h40, "ptr kept");
    // foreign address must be left alone
    host.start();
    host.xfer(8'h52, 1'b1, d, k);
    chk({7'h00, k}, 8'h01, "foreign addr nack");
    host.stop();
    // timeouts: enabled cases first, then the same stalls with them off
    for (int c = 0; c < 4; c++)
    begin
      en = c < 2;
      @(posedge ref_clk);
      timeoutEn <= en;
      repeat (3) @(posedge ref_clk);
      hdr(8'h30 + 8'(c));
      if (c[0])
        host.hiX = 4000;
      else
        #10000;
      host.xfer(8'hf7, 1'b1, d, k);
      chk({7'h00, k}, {7'h00, en}, "ack after stall");
      host.stop();
      chk(mem[8'h30 + 8'(c)], en ? (8'h6a ^ 8'(c)) : 8'hf7, "stall write");
    end
    @(posedge ref_clk);
    timeoutEn <= 1'b0;
    // power states: active, standby, deep (deep wins), active
    for (int c = 0; c < 4; c++)
    begin
      @(posedge ref_clk);
      standbyReqBit <= c == 1 || c == 2;
      deepSleepBit <= c == 2;
      repeat (3) @(posedge ref_clk);
      chk(8'(powerState), c == 1 ? 8'h01 : (c == 2 ? 8'h02 : 8'h00), "state");
      chk({5'h00, touchStatus}, 8'h00, "status cleared");
      touchDetect <= 3'h7;
      @(posedge ref_clk);
      touchDetect <= 3'h0;
      repeat (2) @(posedge ref_clk);
      d = c == 1 ? 8'h04 : (c == 2 ? 8'h00 : 8'h03);
      chk({5'h00, touchStatus}, d, "monitored inputs");
      chk({7'h00, touchAlert}, {7'h00, d != 8'h00}, "alert");
      if (c == 2)
      begin
        chk({7'h00, deviceAwake}, 8'h00, "asleep");
        sawAwake = 1'b0;
        wr(8'h50, '{8'h99});
        chk({7'h00, sawAwake}, 8'h01, "woke for traffic");
        chk(mem[8'h50], 8'h99, "write in deep");
        repeat (8) @(posedge ref_clk);
        chk({7'h00, deviceAwake}, 8'h00, "back asleep");
        chk(8'(powerState), 8'h02, "still deep");
      end
    end
    final_report();
  end
endmodule
